// ### design/bmr_defs.svh
`ifndef BMR_DEFS_SVH
`define BMR_DEFS_SVH

// address map
`define BMR_ADDR_UFLASH 7'h20
`define BMR_ADDR_SFR 7'h60
`define BMR_ADDR_TEMP_LO 7'h60
`define BMR_ADDR_TEMP_HI 7'h61
`define BMR_ADDR_FLASH_CMD 7'h62
`define BMR_ADDR_CLR 7'h63
`define BMR_ADDR_MODE 7'h64
`define BMR_ADDR_CTIME_LO 7'h65
`define BMR_ADDR_CTIME_HI 7'h66
`define BMR_ADDR_DTIME_LO 7'h67
`define BMR_ADDR_DTIME_HI 7'h68
`define BMR_ADDR_SELF_LO 7'h69
`define BMR_ADDR_SELF_HI 7'h6A
`define BMR_ADDR_CHG_LO 7'h6B
`define BMR_ADDR_CHG_HI 7'h6C
`define BMR_ADDR_DIS_LO 7'h6D
`define BMR_ADDR_DIS_HI 7'h6E
`define BMR_ADDR_PROG_DATA 7'h6F
`define BMR_ADDR_PROG_ADDR 7'h70
`define BMR_ADDR_VLOW 7'h71
`define BMR_ADDR_VHIGH 7'h72
`define BMR_ADDR_ID 7'h78
`define BMR_ADDR_IDTOP 7'h7F
// flash command codes
`define BMR_CMD_PROG 8'h0F
`define BMR_CMD_ERASE0 8'h40
`define BMR_CMD_ERASE1 8'h41
`define BMR_CMD_ERASE2 8'h42
`define BMR_CMD_SAVE 8'h45
`define BMR_CMD_LOAD 8'h48
`define BMR_CMD_PDOWN 8'hF6
// clear register bits
`define BMR_CLR_DCR 0
`define BMR_CLR_CCR 1
`define BMR_CLR_SCR 2
`define BMR_CLR_DTC 3
`define BMR_CLR_CTC 4
// mode register bits
`define BMR_MODE_POR 0
`define BMR_MODE_DSLOW 4
`define BMR_MODE_CSLOW 5
`define BMR_MODE_STAT 6
`define BMR_MODE_GPEN 7
`define BMR_MODE_RST 8'h01
// misc
`define BMR_WR_BIT 7
`define BMR_LAST_IDX 5'h1F
`define BMR_SLOW_DIV 8'hFF
`define BMR_ERASED 8'hFF
`endif

// ### design/bmr_pkg.sv
package bmr_pkg;
  typedef enum logic [2:0] {
    ST_BOOT = 3'b001,
    ST_IDLE = 3'b010,
    ST_SAVE = 3'b100
  } bmr_state_t;

  typedef struct packed {
    bmr_state_t st;
    logic [4:0] idx;
    logic wpend;
    logic [6:0] waddr;
    logic [7:0] rdata;
    logic rvalid;
    logic [31:0][7:0] ram;
    logic [31:0][7:0] shadow;
    logic [63:0][7:0] uflash;
    logic [7:0] flash_cmd;
    logic [7:0] prog_data;
    logic [7:0] prog_addr;
    logic [4:0] clr;
    logic [7:0] mode;
    logic [15:0] ccr;
    logic [15:0] dcr;
    logic [15:0] scr;
    logic [15:0] ctc;
    logic [15:0] dtc;
    logic [7:0] ct_pre;
    logic [7:0] dt_pre;
    logic pdown;
  } bmr_regs_t;
endpackage

// ### design/bmr_regs.sv
`timescale 1ns/1ps
`default_nettype none
`include "bmr_defs.svh"

module bmr_regs #(
  parameter logic [7:0] DEVICE_CODE = 8'h5A, // arbitrary value
  parameter logic [7:0] GAIN_CORR = 8'h00,
  parameter logic [4:0] VOLT_OFFSET = 5'h00,
  parameter logic [39:0] ID_RANDOM = 40'h0123456789 // arbitrary value
) (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic cmd_valid_i,
  input wire logic [7:0] cmd_byte_i,
  input wire logic data_valid_i,
  input wire logic [7:0] data_byte_i,
  input wire logic [10:0] vbat_code_i,
  input wire logic [10:0] temp_code_i,
  input wire logic charge_tick_i,
  input wire logic discharge_tick_i,
  input wire logic self_tick_i,
  input wire logic charge_time_tick_i,
  input wire logic discharge_time_tick_i,
  output logic [7:0] rdata_o,
  output logic rdata_valid_o,
  output logic [2:0] wake_threshold_o,
  output logic gp_enable_o,
  output logic power_down_o,
  output logic busy_o
);
  // bytes 7..0 of the identification block
  localparam logic [63:0] ID_ROM = {DEVICE_CODE, 8'h00, ID_RANDOM[39:8],
                                    GAIN_CORR, ID_RANDOM[7:0]};

  bmr_pkg::bmr_regs_t s_r;
  bmr_pkg::bmr_regs_t s_nxt;
  logic [7:0] vhigh_w;
  logic [7:0] boot_byte_w;
  logic [4:0] waddr_lo_w;

  // time counter step; slow mode only advances every 256 base ticks
  function automatic logic [24:0] tstep(input logic [15:0] c, input logic [7:0] p,
                                        input logic slow, input logic tick);
    logic [15:0] cn;
    logic [7:0] pn;
    logic roll;
    cn = c;
    pn = p;
    roll = 1'b0;
    if (tick) begin
      if (slow) begin
        pn = p + 8'h01;
      end
      if (!slow || p == `BMR_SLOW_DIV) begin
        cn = c + 16'h0001;
        roll = (c == 16'hFFFF);
      end
    end
    return {roll, pn, cn};
  endfunction

  // offset over voltage msbs, shared by read path and checks
  assign vhigh_w = {VOLT_OFFSET, vbat_code_i[10:8]};
  assign boot_byte_w = s_r.shadow[s_r.idx];
  assign waddr_lo_w = s_r.waddr[4:0];

  // next-state logic for the whole register bank
  always_comb begin
    logic [7:0] rd;
    logic [6:0] a;
    logic [6:0] uoff;
    logic [24:0] ts;
    rd = 8'h00;
    a = cmd_byte_i[6:0];
    uoff = s_r.prog_addr[6:0] - `BMR_ADDR_UFLASH;
    ts = 25'h0000000;
    s_nxt = s_r;
    s_nxt.rvalid = 1'b0;
    s_nxt.clr = 5'h00;

    // page movers between ram and shadow flash, one byte a cycle
    unique case (s_r.st)
      bmr_pkg::ST_BOOT: begin
        s_nxt.ram[s_r.idx] = s_r.shadow[s_r.idx];
        s_nxt.idx = s_r.idx + 5'h01;
        if (s_r.idx == `BMR_LAST_IDX) begin
          s_nxt.st = bmr_pkg::ST_IDLE;
        end
      end
      bmr_pkg::ST_SAVE: begin
        // flash can only clear bits, so a save ands into old content
        s_nxt.shadow[s_r.idx] = s_r.shadow[s_r.idx] & s_r.ram[s_r.idx];
        s_nxt.idx = s_r.idx + 5'h01;
        if (s_r.idx == `BMR_LAST_IDX) begin
          s_nxt.st = bmr_pkg::ST_IDLE;
        end
      end
      bmr_pkg::ST_IDLE: begin
      end
    endcase

    // read decode over the 123 live locations, holes read zero
    if (a < `BMR_ADDR_UFLASH) begin
      rd = s_r.ram[a[4:0]];
    end else if (a < `BMR_ADDR_SFR) begin
      rd = s_r.uflash[a[5:0] - 6'h20];
    end else if (a >= `BMR_ADDR_ID) begin
      rd = ID_ROM[{a[2:0], 3'b000} +: 8];
    end else begin
      unique case (a)
        `BMR_ADDR_TEMP_LO: rd = temp_code_i[7:0];
        `BMR_ADDR_TEMP_HI: rd = {5'h00, temp_code_i[10:8]};
        `BMR_ADDR_FLASH_CMD: rd = s_r.flash_cmd;
        `BMR_ADDR_CLR: rd = {3'b000, s_r.clr};
        `BMR_ADDR_MODE: rd = s_r.mode;
        `BMR_ADDR_CTIME_LO: rd = s_r.ctc[7:0];
        `BMR_ADDR_CTIME_HI: rd = s_r.ctc[15:8];
        `BMR_ADDR_DTIME_LO: rd = s_r.dtc[7:0];
        `BMR_ADDR_DTIME_HI: rd = s_r.dtc[15:8];
        `BMR_ADDR_SELF_LO: rd = s_r.scr[7:0];
        `BMR_ADDR_SELF_HI: rd = s_r.scr[15:8];
        `BMR_ADDR_CHG_LO: rd = s_r.ccr[7:0];
        `BMR_ADDR_CHG_HI: rd = s_r.ccr[15:8];
        `BMR_ADDR_DIS_LO: rd = s_r.dcr[7:0];
        `BMR_ADDR_DIS_HI: rd = s_r.dcr[15:8];
        `BMR_ADDR_PROG_DATA: rd = s_r.prog_data;
        `BMR_ADDR_PROG_ADDR: rd = s_r.prog_addr;
        `BMR_ADDR_VLOW: rd = vbat_code_i[7:0];
        `BMR_ADDR_VHIGH: rd = vhigh_w;
        default: rd = 8'h00;
      endcase
    end

    // host side: a command byte either reads now or arms a write
    if (cmd_valid_i) begin
      s_nxt.pdown = 1'b0;
      if (cmd_byte_i[`BMR_WR_BIT]) begin
        s_nxt.wpend = 1'b1;
        s_nxt.waddr = a;
      end else begin
        s_nxt.wpend = 1'b0;
        s_nxt.rdata = rd;
        s_nxt.rvalid = 1'b1;
      end
    end else if (data_valid_i && s_r.wpend) begin
      s_nxt.wpend = 1'b0;
      // writes are dropped while a page move owns the arrays
      if (s_r.st == bmr_pkg::ST_IDLE) begin
        if (s_r.waddr < `BMR_ADDR_UFLASH) begin
          s_nxt.ram[waddr_lo_w] = data_byte_i;
        end else begin
          unique case (s_r.waddr)
            `BMR_ADDR_PROG_DATA: s_nxt.prog_data = data_byte_i;
            `BMR_ADDR_PROG_ADDR: s_nxt.prog_addr = data_byte_i;
            `BMR_ADDR_CLR: s_nxt.clr = data_byte_i[4:0];
            `BMR_ADDR_MODE: s_nxt.mode = data_byte_i;
            `BMR_ADDR_FLASH_CMD: begin
              s_nxt.flash_cmd = data_byte_i;
              unique case (data_byte_i)
                `BMR_CMD_PROG: begin
                  // programming ands the data into the addressed byte
                  if (s_r.prog_addr[6:0] < `BMR_ADDR_UFLASH) begin
                    s_nxt.shadow[s_r.prog_addr[4:0]] =
                      s_r.shadow[s_r.prog_addr[4:0]] & s_r.prog_data;
                  end else if (s_r.prog_addr[6:0] < `BMR_ADDR_SFR) begin
                    s_nxt.uflash[uoff[5:0]] = s_r.uflash[uoff[5:0]] & s_r.prog_data;
                  end
                end
                `BMR_CMD_ERASE0: s_nxt.shadow = {32{`BMR_ERASED}};
                `BMR_CMD_ERASE1: s_nxt.uflash[31:0] = {32{`BMR_ERASED}};
                `BMR_CMD_ERASE2: s_nxt.uflash[63:32] = {32{`BMR_ERASED}};
                `BMR_CMD_SAVE: begin
                  s_nxt.st = bmr_pkg::ST_SAVE;
                  s_nxt.idx = 5'h00;
                end
                `BMR_CMD_LOAD: begin
                  s_nxt.st = bmr_pkg::ST_BOOT;
                  s_nxt.idx = 5'h00;
                end
                `BMR_CMD_PDOWN: s_nxt.pdown = 1'b1;
                default: s_nxt.pdown = s_r.pdown;
              endcase
            end
            default: s_nxt.prog_data = s_r.prog_data;
          endcase
        end
      end
    end

    // counters; a pending clear wins over a tick in the same cycle
    s_nxt.dcr = s_r.clr[`BMR_CLR_DCR] ? 16'h0000 : s_r.dcr + {15'h0000, discharge_tick_i};
    s_nxt.ccr = s_r.clr[`BMR_CLR_CCR] ? 16'h0000 : s_r.ccr + {15'h0000, charge_tick_i};
    s_nxt.scr = s_r.clr[`BMR_CLR_SCR] ? 16'h0000 : s_r.scr + {15'h0000, self_tick_i};
    if (s_r.clr[`BMR_CLR_CTC]) begin
      s_nxt.ctc = 16'h0000;
      s_nxt.ct_pre = 8'h00;
      s_nxt.mode[`BMR_MODE_CSLOW] = 1'b0;
    end else begin
      ts = tstep(s_r.ctc, s_r.ct_pre, s_r.mode[`BMR_MODE_CSLOW], charge_time_tick_i);
      s_nxt.ctc = ts[15:0];
      s_nxt.ct_pre = ts[23:16];
      if (ts[24]) begin
        s_nxt.mode[`BMR_MODE_CSLOW] = 1'b1; // rollover beats a host write
      end
    end
    if (s_r.clr[`BMR_CLR_DTC]) begin
      s_nxt.dtc = 16'h0000;
      s_nxt.dt_pre = 8'h00;
      s_nxt.mode[`BMR_MODE_DSLOW] = 1'b0;
    end else begin
      ts = tstep(s_r.dtc, s_r.dt_pre, s_r.mode[`BMR_MODE_DSLOW], discharge_time_tick_i);
      s_nxt.dtc = ts[15:0];
      s_nxt.dt_pre = ts[23:16];
      if (ts[24]) begin
        s_nxt.mode[`BMR_MODE_DSLOW] = 1'b1;
      end
    end
    // status bit mirrors a running page move
    s_nxt.mode[`BMR_MODE_STAT] = (s_nxt.st != bmr_pkg::ST_IDLE);
  end

  // state register; flash arrays survive reset, ram refills by boot copy
  always_ff @(posedge mclk_i) begin
    s_r <= s_nxt;
    if (!rst_n_i) begin
      s_r.st <= bmr_pkg::ST_BOOT;
      s_r.idx <= 5'h00;
      s_r.wpend <= 1'b0;
      s_r.waddr <= 7'h00;
      s_r.rdata <= 8'h00;
      s_r.rvalid <= 1'b0;
      s_r.flash_cmd <= 8'h00;
      s_r.prog_data <= 8'h00;
      s_r.prog_addr <= 8'h00;
      s_r.clr <= 5'h00;
      s_r.mode <= `BMR_MODE_RST | 8'h40;
      s_r.ccr <= 16'h0000;
      s_r.dcr <= 16'h0000;
      s_r.scr <= 16'h0000;
      s_r.ctc <= 16'h0000;
      s_r.dtc <= 16'h0000;
      s_r.ct_pre <= 8'h00;
      s_r.dt_pre <= 8'h00;
      s_r.pdown <= 1'b0;
    end
  end

  assign rdata_o = s_r.rdata;
  assign rdata_valid_o = s_r.rvalid;
  assign wake_threshold_o = s_r.mode[3:1];
  assign gp_enable_o = s_r.mode[`BMR_MODE_GPEN];
  assign power_down_o = s_r.pdown;
  assign busy_o = s_r.mode[`BMR_MODE_STAT];

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);

  read_answer_a: assert property (cmd_valid_i && !cmd_byte_i[7] |=> rdata_valid_o)
    else $error("read command gave no answer");
  id_code_a: assert property (cmd_valid_i && cmd_byte_i == 8'h7F |=> rdata_o == DEVICE_CODE)
    else $error("top id byte wrong");
  gain_byte_a: assert property (cmd_valid_i && cmd_byte_i == 8'h79 |=> rdata_o == GAIN_CORR)
    else $error("gain byte wrong");
  volt_high_a: assert property (cmd_valid_i && cmd_byte_i == 8'h72 |=> rdata_o == $past(vhigh_w))
    else $error("voltage high byte wrong");
  ram_write_a: assert property (s_r.wpend && data_valid_i && !cmd_valid_i && !busy_o
    && s_r.waddr < 7'h20 |=> s_r.ram[$past(waddr_lo_w)] == $past(data_byte_i))
    else $error("ram write lost");
  boot_len_a: assert property (s_r.st == bmr_pkg::ST_BOOT && s_r.idx == 5'h00
    |-> ##31 busy_o ##1 !busy_o)
    else $error("boot copy length wrong");
  boot_copy_a: assert property (s_r.st == bmr_pkg::ST_BOOT
    |=> s_r.ram[$past(s_r.idx)] == $past(boot_byte_w))
    else $error("boot copy byte wrong");
  clr_ccr_a: assert property (s_r.clr[1] |=> s_r.ccr == 16'h0000)
    else $error("charge counter not cleared");
  save_start_a: assert property (s_r.wpend && data_valid_i && !cmd_valid_i && !busy_o
    && s_r.waddr == 7'h62 && data_byte_i == 8'h45 |=> busy_o [*8])
    else $error("save did not start");

  boot_done_c: cover property (busy_o ##1 !busy_o);
  clear_c: cover property (s_r.clr[4] ##1 s_r.clr == 5'h00);
  read_c: cover property (cmd_valid_i ##1 rdata_valid_o);
endmodule
`default_nettype wire

// ### tb/bmr_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module bmr_host_model (
  input wire logic mclk_i,
  output logic cmd_valid_o,
  output logic [7:0] cmd_byte_o,
  output logic data_valid_o,
  output logic [7:0] data_byte_o,
  input wire logic [7:0] rdata_i,
  input wire logic rdata_valid_i
);
  // lines idle low at start; after a byte they show its inverse so stale data never looks valid
  initial begin
    cmd_valid_o = 1'b0;
    cmd_byte_o = 8'h00;
    data_valid_o = 1'b0;
    data_byte_o = 8'h00;
  end
  // write: command byte, then the data byte on the very next edge
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    cmd_valid_o <= 1'b1;
    cmd_byte_o <= {1'b1, a};
    @(posedge mclk_i);
    cmd_valid_o <= 1'b0;
    cmd_byte_o <= ~{1'b1, a};
    data_valid_o <= 1'b1;
    data_byte_o <= d;
    @(posedge mclk_i);
    data_valid_o <= 1'b0;
    data_byte_o <= ~d;
  endtask
  // read: answer must stand one cycle after the command edge, else unknown is returned
  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    @(posedge mclk_i);
    cmd_valid_o <= 1'b1;
    cmd_byte_o <= {1'b0, a};
    @(posedge mclk_i);
    cmd_valid_o <= 1'b0;
    cmd_byte_o <= ~{1'b0, a};
    #1;
    d = (rdata_valid_i === 1'b1) ? rdata_i : 8'hXX;
  endtask
endmodule
`default_nettype wire

// ### tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam logic [7:0] DEV_CODE = 8'h3C; // arbitrary value
  logic mclk_i, rst_n_i, cmd_valid, data_valid, rvalid, gpen, pdown, busy;
  logic [7:0] cmd_byte, data_byte, rdata, d;
  logic [10:0] vbat, temp;
  logic [4:0] tick;
  logic [2:0] wake;
  int failures, cmp_count;

  bmr_regs #(.DEVICE_CODE(DEV_CODE), .GAIN_CORR(8'hF6), .VOLT_OFFSET(5'h1A)) uut (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .cmd_valid_i(cmd_valid), .cmd_byte_i(cmd_byte),
    .data_valid_i(data_valid), .data_byte_i(data_byte), .vbat_code_i(vbat),
    .temp_code_i(temp), .charge_tick_i(tick[0]), .discharge_tick_i(tick[1]),
    .self_tick_i(tick[2]), .charge_time_tick_i(tick[3]), .discharge_time_tick_i(tick[4]),
    .rdata_o(rdata), .rdata_valid_o(rvalid), .wake_threshold_o(wake),
    .gp_enable_o(gpen), .power_down_o(pdown), .busy_o(busy));

  bmr_host_model host (
    .mclk_i(mclk_i), .cmd_valid_o(cmd_valid), .cmd_byte_o(cmd_byte),
    .data_valid_o(data_valid), .data_byte_o(data_byte), .rdata_i(rdata),
    .rdata_valid_i(rvalid));

  // 100 MHz clock
  initial begin
    mclk_i = 1'b0;
    forever #5 mclk_i = ~mclk_i;
  end

  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      failures++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic rdchk(input string n, input logic [6:0] a, input logic [7:0] e);
    logic [7:0] v;
    host.rd(a, v);
    chk(n, e, v);
  endtask
  // bounded wait for a page move to finish; a hang shows up as a busy mismatch
  task automatic wait_idle();
    int k;
    k = 0;
    #1;
    while (busy !== 1'b0 && k < 60) begin
      @(posedge mclk_i);
      #1;
      k++;
    end
    chk("busy", 8'h00, {7'h00, busy});
  endtask
  task automatic do_reset();
    rst_n_i <= 1'b0;
    repeat (10) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    wait_idle();
  endtask
  task automatic pulse(input int b, input int n);
    repeat (n) begin
      @(posedge mclk_i);
      tick[b] <= 1'b1;
      @(posedge mclk_i);
      tick[b] <= 1'b0;
    end
  endtask
  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // watchdog: the whole sequence needs well under 2000 cycles
  initial begin
    #100000;
    failures++;
    results();
  end

  initial begin
    failures = 0;
    cmp_count = 0;
    rst_n_i = 1'b0;
    tick = 5'h00;
    vbat = 11'h5A3;
    temp = 11'h4C7;
    do_reset();
    // flash starts unknown, so erase every page first
    host.wr(7'h62, 8'h40);
    host.wr(7'h62, 8'h41);
    host.wr(7'h62, 8'h42);
    rdchk("uflash_erased", 7'h5F, 8'hFF);
    host.wr(7'h00, 8'hA5);
    host.wr(7'h1F, 8'h3C);
    rdchk("ram0", 7'h00, 8'hA5);
    rdchk("ram31", 7'h1F, 8'h3C);
    host.wr(7'h62, 8'h45);
    wait_idle();
    host.wr(7'h00, 8'h00);
    rdchk("ram0_cleared", 7'h00, 8'h00);
    host.wr(7'h62, 8'h48);
    wait_idle();
    rdchk("ram0_loaded", 7'h00, 8'hA5);
    host.wr(7'h1F, 8'h00);
    do_reset();
    rdchk("ram31_boot", 7'h1F, 8'h3C);
    rdchk("mode_por", 7'h64, 8'h01);
    $display("test shadow done");
    // byte programming ands data into user flash
    host.wr(7'h70, 8'h20);
    host.wr(7'h6F, 8'h5A);
    host.wr(7'h62, 8'h0F);
    rdchk("prog1", 7'h20, 8'h5A);
    host.wr(7'h6F, 8'h0F);
    host.wr(7'h62, 8'h0F);
    rdchk("prog_and", 7'h20, 8'h0A);
    host.wr(7'h20, 8'hFF);
    rdchk("flash_direct", 7'h20, 8'h0A);
    rdchk("prog_addr", 7'h70, 8'h20);
    $display("test program done");
    rdchk("id_top", 7'h7F, DEV_CODE);
    rdchk("id_zero", 7'h7E, 8'h00);
    rdchk("gain", 7'h79, 8'hF6);
    rdchk("v_low", 7'h71, 8'hA3);
    rdchk("v_high", 7'h72, 8'hD5);
    // host side decodes the offset: sign set, magnitude ten counts of 8 mV
    host.rd(7'h72, d);
    chk("offset_sign", 8'h01, {7'h00, d[7]});
    chk("offset_mag", 8'h0A, {4'h0, d[6:3]});
    host.wr(7'h71, 8'h00);
    rdchk("v_low_ro", 7'h71, 8'hA3);
    rdchk("reserved", 7'h75, 8'h00);
    rdchk("temp_low", 7'h60, 8'hC7);
    rdchk("temp_high", 7'h61, 8'h04);
    $display("test map done");
    // clear everything, then count known pulses
    host.wr(7'h63, 8'h1F);
    repeat (3) @(posedge mclk_i);
    pulse(0, 3);
    pulse(1, 1);
    pulse(2, 2);
    pulse(3, 1);
    pulse(4, 2);
    rdchk("ccr_low", 7'h6B, 8'h03);
    rdchk("ccr_high", 7'h6C, 8'h00);
    rdchk("dcr_low", 7'h6D, 8'h01);
    rdchk("scr_low", 7'h69, 8'h02);
    rdchk("scr_high", 7'h6A, 8'h00);
    rdchk("ctc_low", 7'h65, 8'h01);
    rdchk("dtc_low", 7'h67, 8'h02);
    host.wr(7'h63, 8'h02);
    repeat (2) @(posedge mclk_i);
    rdchk("ccr_cleared", 7'h6B, 8'h00);
    rdchk("clr_self", 7'h63, 8'h00);
    rdchk("scr_kept", 7'h69, 8'h02);
    $display("test counters done");
    host.wr(7'h64, 8'h8E);
    repeat (2) @(posedge mclk_i);
    #1;
    chk("wake", 8'h07, {5'h00, wake});
    chk("gpen", 8'h01, {7'h00, gpen});
    host.rd(7'h64, d);
    chk("mode", 8'h8E, d & 8'hFE);
    host.wr(7'h62, 8'hF6);
    repeat (2) @(posedge mclk_i);
    #1;
    chk("pdown", 8'h01, {7'h00, pdown});
    rdchk("flash_cmd", 7'h62, 8'hF6);
    chk("pdown_off", 8'h00, {7'h00, pdown});
    $display("test mode done");
    results();
  end
endmodule
`default_nettype wire
